// [verilog/sio_io_logic.sv]
/*
 * Controller-connector I/O logic: overtravel inhibit, command pulse decode,
 * fault, in-position/at-speed, brake release and warning outputs, with a
 * Wishbone classic register slave and a level interrupt.
 * Assumes servo-loop quantities arrive synchronous to i_sys_clk and that pin
 * inputs are asynchronous and already converted to logic levels.
 */
`timescale 1ns/1ps
module sio_io_logic
	import sio_pkg::*;
#(
	parameter int HOLD_CYC = WARN_HOLD_CYC
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst,
	input  wire logic             i_clk_en,
	input  wire logic             i_wb_cyc,
	input  wire logic             i_wb_stb,
	input  wire logic             i_wb_we,
	input  wire logic [ADR_W-1:0] i_wb_adr,
	input  wire logic [3:0]       i_wb_sel,
	input  wire logic [DAT_W-1:0] i_wb_dat,
	output logic      [DAT_W-1:0] o_wb_dat,
	output logic                  o_wb_ack,
	input  wire logic             i_cw_limit_inhibit,
	input  wire logic             i_ccw_limit_inhibit,
	input  wire logic             i_cmd_pulse_pos,
	input  wire logic             i_cmd_dir_pos,
	input  wire logic             i_alarm_detect,
	input  wire logic [VAL_W-1:0] i_pos_err,
	input  wire logic [VAL_W-1:0] i_motor_speed,
	input  wire logic [VAL_W-1:0] i_eff_torque,
	input  wire logic             i_torque_limiting,
	input  wire logic             i_regen_warn,
	output logic                  o_torque_enable,
	output logic                  o_dyn_brake_allow,
	output logic                  o_cmd_step,
	output logic                  o_cmd_dir,
	output logic                  o_servo_fault_out,
	output logic                  o_position_or_speed_reached,
	output logic                  o_holding_brake_release,
	output logic                  o_warning_out,
	output logic                  o_irq
);
	localparam logic [25:0] HOLD = 26'(HOLD_CYC);

	logic [CTRL_W-1:0] ctrl_ff;
	logic [VAL_W-1:0]  inpos_range_cfg_ff;
	logic [VAL_W-1:0]  speed_reached_cfg_ff;
	logic [VAL_W-1:0]  zero_speed_cfg_ff;
	logic [VAL_W-1:0]  ovl_trip_ff;
	logic [NIRQ-1:0]   irq_st_ff;
	logic [NIRQ-1:0]   irq_mask_ff;
	logic [DAT_W-1:0]  pcount_ff;
	logic [DAT_W-1:0]  rdat;
	logic [DAT_W-1:0]  wmask;
	logic [NIRQ-1:0]   irq_evt;
	logic [SYNC_W-1:0] pin_sync;
	logic              wr_en;
	logic              ot_dis;
	logic              dyn_cfg;
	logic              vel_mode;
	logic              brake_req;
	logic [2:0]        warn_sel;
	sio_fmt_t          fmt;
	logic              cw_closed;
	logic              ccw_closed;
	logic              pa;
	logic              pb;
	logic              pa_ff;
	logic              pb_ff;
	logic              nxt_step;
	logic              nxt_dir;
	logic              cw_stop;
	logic              ccw_stop;
	logic              warn_cond;
	logic              reach_cond;
	logic [25:0]       hold_cnt_ff;
	logic              torque_en_ff;
	logic              dyn_ff;
	logic              fault_ff;
	logic              reach_ff;
	logic              brake_ff;
	logic              warn_ff;
	logic              step_ff;
	logic              dir_ff;
	logic [23:0]       ovl_lhs;
	logic [23:0]       ovl_rhs;

	assign ot_dis    = ctrl_ff[CB_OT_DIS];
	assign dyn_cfg   = ctrl_ff[CB_DYN_CFG];
	assign fmt       = sio_fmt_t'(ctrl_ff[CB_FMT_LO +: 2]);
	assign vel_mode  = ctrl_ff[CB_VEL_MODE];
	assign warn_sel  = ctrl_ff[CB_WSEL_LO +: 3];
	assign brake_req = ctrl_ff[CB_BRAKE];

	// pin inputs pass two flops before any logic reads them
	sio_sync #(
		.W(SYNC_W)
	) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_clk_en  (i_clk_en),
		.i_async   ({i_cmd_dir_pos, i_cmd_pulse_pos, i_ccw_limit_inhibit, i_cw_limit_inhibit}),
		.o_sync    (pin_sync)
	);
	assign cw_closed  = pin_sync[0];
	assign ccw_closed = pin_sync[1];
	assign pa         = pin_sync[2];
	assign pb         = pin_sync[3];

	// register bus
	assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
	assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= '0;
		end else if (i_clk_en) begin
			o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
			o_wb_dat <= rdat;
		end
	end

	always_comb begin
		rdat = '0;
		unique case (i_wb_adr)
			ADR_CTRL:     rdat[CTRL_W-1:0] = ctrl_ff;
			ADR_INPOS:    rdat[VAL_W-1:0] = inpos_range_cfg_ff;
			ADR_SPEED:    rdat[VAL_W-1:0] = speed_reached_cfg_ff;
			ADR_ZERO:     rdat[VAL_W-1:0] = zero_speed_cfg_ff;
			ADR_OVL_TRIP: rdat[VAL_W-1:0] = ovl_trip_ff;
			ADR_STATUS:   rdat[7:0] = {warn_ff, brake_ff, reach_ff, fault_ff,
				dyn_ff, torque_en_ff, ccw_closed, cw_closed};
			ADR_IRQ_ST:   rdat[NIRQ-1:0] = irq_st_ff;
			ADR_IRQ_MASK: rdat[NIRQ-1:0] = irq_mask_ff;
			ADR_PCOUNT:   rdat = pcount_ff;
			default:      rdat = '0;
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_ff              <= CTRL_RST;
			inpos_range_cfg_ff   <= VAL_RST;
			speed_reached_cfg_ff <= VAL_RST;
			zero_speed_cfg_ff    <= VAL_RST;
			ovl_trip_ff          <= VAL_RST;
			irq_mask_ff          <= '0;
		end else if (i_clk_en && wr_en) begin
			unique case (i_wb_adr)
				ADR_CTRL:     ctrl_ff <= (ctrl_ff & ~wmask[CTRL_W-1:0]) | (i_wb_dat[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
				ADR_INPOS:    inpos_range_cfg_ff <= (inpos_range_cfg_ff & ~wmask[VAL_W-1:0])
					| (i_wb_dat[VAL_W-1:0] & wmask[VAL_W-1:0]);
				ADR_SPEED:    speed_reached_cfg_ff <= (speed_reached_cfg_ff & ~wmask[VAL_W-1:0])
					| (i_wb_dat[VAL_W-1:0] & wmask[VAL_W-1:0]);
				ADR_ZERO:     zero_speed_cfg_ff <= (zero_speed_cfg_ff & ~wmask[VAL_W-1:0])
					| (i_wb_dat[VAL_W-1:0] & wmask[VAL_W-1:0]);
				ADR_OVL_TRIP: ovl_trip_ff <= (ovl_trip_ff & ~wmask[VAL_W-1:0]) | (i_wb_dat[VAL_W-1:0] & wmask[VAL_W-1:0]);
				ADR_IRQ_MASK: irq_mask_ff <= (irq_mask_ff & ~wmask[NIRQ-1:0]) | (i_wb_dat[NIRQ-1:0] & wmask[NIRQ-1:0]);
				default: ;
			endcase
		end
	end

	// sticky events: a new event wins over a write-one clear in the same cycle
	assign irq_evt[IRQ_CW]    = cw_stop && torque_en_ff;
	assign irq_evt[IRQ_CCW]   = ccw_stop && torque_en_ff;
	assign irq_evt[IRQ_FAULT] = i_alarm_detect && fault_ff;
	assign irq_evt[IRQ_WARN]  = warn_cond && !warn_ff;
	assign irq_evt[IRQ_REACH] = reach_cond && !reach_ff;

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_st_ff <= '0;
		end else if (i_clk_en) begin
			if (wr_en && i_wb_adr == ADR_IRQ_ST) begin
				irq_st_ff <= (irq_st_ff & ~(i_wb_dat[NIRQ-1:0] & wmask[NIRQ-1:0])) | irq_evt;
			end else begin
				irq_st_ff <= irq_st_ff | irq_evt;
			end
		end
	end
	assign o_irq = |(irq_st_ff & irq_mask_ff);

	// overtravel inhibit: an open contact stops torque unless disabled
	assign cw_stop  = !ot_dis && !cw_closed;
	assign ccw_stop = !ot_dis && !ccw_closed;

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			torque_en_ff <= 1'b1;
			dyn_ff       <= 1'b0;
		end else if (i_clk_en) begin
			torque_en_ff <= !(cw_stop || ccw_stop);
			dyn_ff       <= (cw_stop || ccw_stop) && !dyn_cfg;
		end
	end
	assign o_torque_enable   = torque_en_ff;
	assign o_dyn_brake_allow = dyn_ff;

	// command pulse decode in the selected format
	always_comb begin
		nxt_step = 1'b0;
		nxt_dir  = dir_ff;
		unique case (fmt)
			FMT_QUAD: begin
				nxt_step = (pa ^ pa_ff) || (pb ^ pb_ff);
				nxt_dir  = pa_ff ^ pb;
			end
			FMT_CWCCW: begin
				nxt_step = (pa && !pa_ff) ^ (pb && !pb_ff);
				nxt_dir  = pb && !pb_ff;
			end
			FMT_PSIGN: begin
				nxt_step = pa && !pa_ff;
				nxt_dir  = pb;
			end
			default: begin
				nxt_step = 1'b0;
				nxt_dir  = dir_ff;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			pa_ff     <= 1'b0;
			pb_ff     <= 1'b0;
			step_ff   <= 1'b0;
			dir_ff    <= 1'b0;
			pcount_ff <= '0;
		end else if (i_clk_en) begin
			pa_ff   <= pa;
			pb_ff   <= pb;
			step_ff <= nxt_step;
			dir_ff  <= nxt_dir;
			if (nxt_step) begin
				pcount_ff <= nxt_dir ? pcount_ff - 32'h1 : pcount_ff + 32'h1;
			end
		end
	end
	assign o_cmd_step = step_ff;
	assign o_cmd_dir  = dir_ff;

	// status outputs, high meaning transistor on
	assign reach_cond = vel_mode ? (i_motor_speed > speed_reached_cfg_ff)
		: (i_pos_err < inpos_range_cfg_ff);

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			fault_ff <= 1'b0;
			reach_ff <= 1'b0;
			brake_ff <= 1'b0;
		end else if (i_clk_en) begin
			fault_ff <= !i_alarm_detect;
			reach_ff <= reach_cond;
			brake_ff <= brake_req && !i_alarm_detect;
		end
	end
	assign o_servo_fault_out           = fault_ff;
	assign o_position_or_speed_reached = reach_ff;
	assign o_holding_brake_release     = brake_ff;

	// warning selection and minimum on time
	assign ovl_lhs = i_eff_torque * FULL_PCT;
	assign ovl_rhs = ovl_trip_ff * OVL_PCT;

	always_comb begin
		unique case (warn_sel)
			WS_TLIM:  warn_cond = i_torque_limiting;
			WS_ZSPD:  warn_cond = i_motor_speed < zero_speed_cfg_ff;
			WS_BOTH:  warn_cond = i_regen_warn || (ovl_lhs > ovl_rhs);
			WS_REGEN: warn_cond = i_regen_warn;
			WS_OVL:   warn_cond = ovl_lhs > ovl_rhs;
			default:  warn_cond = 1'b0;
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			hold_cnt_ff <= '0;
			warn_ff     <= 1'b0;
		end else if (i_clk_en) begin
			if (warn_cond) begin
				hold_cnt_ff <= HOLD;
				warn_ff     <= 1'b1;
			end else if (hold_cnt_ff != '0) begin
				hold_cnt_ff <= hold_cnt_ff - 26'h1;
				warn_ff     <= hold_cnt_ff != 26'h1;
			end else begin
				warn_ff <= 1'b0;
			end
		end
	end
	assign o_warning_out = warn_ff;

	property p_cw_stop;
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_clk_en && !ot_dis && !cw_closed) |=> !o_torque_enable;
	endproperty
	a_cw_stop: assert property (p_cw_stop) else $error("cw overtravel did not stop torque");
	property p_ccw_stop;
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_clk_en && !ot_dis && !ccw_closed) |=> !o_torque_enable;
	endproperty
	a_ccw_stop: assert property (p_ccw_stop) else $error("ccw overtravel did not stop torque");
	property p_ot_dis;
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_clk_en && ot_dis) |=> (o_torque_enable && !o_dyn_brake_allow);
	endproperty
	a_ot_dis: assert property (p_ot_dis) else $error("disabled overtravel still acted");
	property p_dyn;
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_clk_en && (cw_stop || ccw_stop)) |=> (o_dyn_brake_allow == !$past(dyn_cfg));
	endproperty
	a_dyn: assert property (p_dyn) else $error("dynamic brake permission wrong");
	property p_psign;
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_clk_en && fmt == FMT_PSIGN && pa && !pa_ff) |=> (o_cmd_step && o_cmd_dir == $past(pb));
	endproperty
	a_psign: assert property (p_psign) else $error("pulse and sign step missed");
	property p_fault;
		@(posedge i_sys_clk) disable iff (i_rst)
		i_clk_en |=> (o_servo_fault_out == !$past(i_alarm_detect));
	endproperty
	a_fault: assert property (p_fault) else $error("fault output does not follow alarm");
	property p_inpos;
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_clk_en && !vel_mode) |=> (o_position_or_speed_reached == ($past(i_pos_err) < $past(inpos_range_cfg_ff)));
	endproperty
	a_inpos: assert property (p_inpos) else $error("in-position output wrong");
	property p_atspd;
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_clk_en && vel_mode && i_motor_speed > speed_reached_cfg_ff) |=> o_position_or_speed_reached;
	endproperty
	a_atspd: assert property (p_atspd) else $error("at-speed output missing");
	property p_brake;
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_clk_en && (i_alarm_detect || !brake_req)) |=> !o_holding_brake_release;
	endproperty
	a_brake: assert property (p_brake) else $error("brake released without request");
	property p_hold;
		@(posedge i_sys_clk) disable iff (i_rst)
		$fell(o_warning_out) |-> ($past(hold_cnt_ff) == 26'h1 && !$past(warn_cond));
	endproperty
	a_hold: assert property (p_hold) else $error("warning dropped before hold time");
	property p_tlim;
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_clk_en && warn_sel == WS_TLIM && i_torque_limiting) |=> o_warning_out;
	endproperty
	a_tlim: assert property (p_tlim) else $error("torque limit warning missing");
	property p_zspd;
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_clk_en && warn_sel == WS_ZSPD && i_motor_speed < zero_speed_cfg_ff) |=> o_warning_out;
	endproperty
	a_zspd: assert property (p_zspd) else $error("zero speed warning missing");
	property p_ovl;
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_clk_en && warn_sel == WS_OVL && ovl_lhs > ovl_rhs) |=> o_warning_out;
	endproperty
	a_ovl: assert property (p_ovl) else $error("overload warning missing");
	property p_both;
		@(posedge i_sys_clk) disable iff (i_rst)
		(i_clk_en && warn_sel == WS_BOTH && i_regen_warn) |=> o_warning_out;
	endproperty
	a_both: assert property (p_both) else $error("combined warning missing");
endmodule

// [verilog/sio_pkg.sv]
/*
 * Constants for the controller-connector I/O logic: register map, field
 * layout, reset values, pulse formats, warning selections and timing.
 * Assumes a single 50 MHz system clock and a classic Wishbone register bus.
 */
// Notes on behaviour
// - an open clockwise overtravel input stops motor torque.
// - an open counter-clockwise overtravel input stops motor torque.
// - overtravel disable at 1 ignores both overtravel inputs, and it resets to 1.
// - dynamic-brake-at-overtravel at its default 0 lets the dynamic brake act during overtravel.
// - the pulse format selects quadrature, cw/ccw pulse trains or pulse plus sign, and that form is decoded.
// - the fault output transistor is off while an alarm is detected and on otherwise.
// - in position mode the shared status output is on while position error is below the in-position range.
// - in velocity mode the shared status output is on while speed exceeds the at-speed threshold.
// - the brake release output is on to release the holding brake and off to engage it.
// - the warning output follows the selected condition and stays on at least one second.
// - warning selection 0 drives the warning on while torque limiting is active.
// - warning selection 1 drives the warning on while speed is below the zero-speed threshold.
// - warning selection 4 drives the warning on when effective torque exceeds 85% of overload trip.
// - the combined selection drives the warning on for over-regeneration or overload.
package sio_pkg;
	localparam int           ADR_W         = 8;
	localparam int           DAT_W         = 32;
	localparam int           VAL_W         = 16;
	localparam logic [7:0]   ADR_CTRL      = 8'h00;
	localparam logic [7:0]   ADR_INPOS     = 8'h04;
	localparam logic [7:0]   ADR_SPEED     = 8'h08;
	localparam logic [7:0]   ADR_ZERO      = 8'h0c;
	localparam logic [7:0]   ADR_OVL_TRIP  = 8'h10;
	localparam logic [7:0]   ADR_STATUS    = 8'h14;
	localparam logic [7:0]   ADR_IRQ_ST    = 8'h18;
	localparam logic [7:0]   ADR_IRQ_MASK  = 8'h1c;
	localparam logic [7:0]   ADR_PCOUNT    = 8'h20;
	// control register fields
	localparam int           CB_OT_DIS     = 0;
	localparam int           CB_DYN_CFG    = 1;
	localparam int           CB_FMT_LO     = 2;
	localparam int           CB_VEL_MODE   = 4;
	localparam int           CB_WSEL_LO    = 5;
	localparam int           CB_BRAKE      = 8;
	localparam int           CTRL_W        = 9;
	localparam logic [8:0]   CTRL_RST      = 9'h001;
	localparam logic [15:0]  VAL_RST       = 16'h0000;
	localparam int           NIRQ          = 5;
	localparam int           IRQ_CW        = 0;
	localparam int           IRQ_CCW       = 1;
	localparam int           IRQ_FAULT     = 2;
	localparam int           IRQ_WARN      = 3;
	localparam int           IRQ_REACH     = 4;
	typedef enum logic [1:0] {FMT_QUAD, FMT_CWCCW, FMT_PSIGN, FMT_RSVD} sio_fmt_t;
	localparam logic [2:0]   WS_TLIM       = 3'h0;
	localparam logic [2:0]   WS_ZSPD       = 3'h1;
	localparam logic [2:0]   WS_BOTH       = 3'h2;
	localparam logic [2:0]   WS_REGEN      = 3'h3;
	localparam logic [2:0]   WS_OVL        = 3'h4;
	localparam logic [7:0]   OVL_PCT       = 8'h55;
	localparam logic [7:0]   FULL_PCT      = 8'h64;
	localparam int           CLK_HZ        = 50_000_000;
	localparam int           WARN_HOLD_MS  = 1000;
	localparam int           WARN_HOLD_CYC = WARN_HOLD_MS * (CLK_HZ / 1000);
	localparam int           SYNC_W        = 4;
endpackage

// [verilog/sio_sync.sv]
/*
 * Two-flop synchroniser for a group of independent asynchronous levels.
 * Assumes each bit is a slow level or pulse wider than two clock periods.
 */
`timescale 1ns/1ps
module sio_sync #(
	parameter int W = 4
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst,
	input  wire logic         i_clk_en,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else if (i_clk_en) begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;
endmodule

// [verif/sio_host_model.sv]
/*
 * Host controller model: drives the command pulse and overtravel pins.
 * Assumes the bench clock; counts the decoded steps that come back.
 */
`timescale 1ns/1ps
module sio_host_model (
	input  wire logic i_sys_clk,
	input  wire logic i_cmd_step,
	input  wire logic i_cmd_dir,
	output logic      o_pulse,
	output logic      o_dir,
	output logic      o_cw_closed,
	output logic      o_ccw_closed
);
	int         n_up = 0;
	int         n_dn = 0;
	logic [1:0] gidx = 2'h0;
	initial begin
		o_pulse = 1'b0;
		o_dir = 1'b0;
		o_cw_closed = 1'b1;
		o_ccw_closed = 1'b1;
	end
	always @(posedge i_sys_clk) begin
		if (i_cmd_step === 1'b1 && i_cmd_dir === 1'b1) n_dn <= n_dn + 1;
		else if (i_cmd_step === 1'b1) n_up <= n_up + 1;
	end
	// 250 cycles per pulse period keeps 200 kpps
	task automatic gap;
		repeat (125) @(posedge i_sys_clk);
	endtask
	task automatic lim(input logic cw, input logic ccw);
		@(posedge i_sys_clk);
		o_cw_closed <= cw;
		o_ccw_closed <= ccw;
	endtask
	task automatic step(input logic [1:0] fmt, input logic neg);
		@(posedge i_sys_clk);
		case (fmt)
		2'h0: begin
			gidx = neg ? gidx - 2'h1 : gidx + 2'h1;
			o_pulse <= (gidx == 2'h1) || (gidx == 2'h2);
			o_dir <= gidx[1];
			gap();
			gap();
		end
		2'h1: begin
			if (neg) o_dir <= 1'b1;
			else o_pulse <= 1'b1;
			gap();
			o_dir <= 1'b0;
			o_pulse <= 1'b0;
			gap();
		end
		default: begin
			o_dir <= neg;
			gap();
			o_pulse <= 1'b1;
			gap();
			o_pulse <= 1'b0;
			gap();
		end
		endcase
	endtask
endmodule

// [verif/test_sio_io_logic.sv]
/*
 * Self-checking bench for the connector I/O logic.
 * Assumes the host model file and a short warning hold of 20 cycles.
 */
`timescale 1ns/1ps
module test_sio_io_logic
	import sio_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        en = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic        alarm = 1'b0;
	logic        tlim = 1'b0;
	logic        regen = 1'b0;
	logic [15:0] pos_err = 16'h0;
	logic [15:0] speed = 16'h0;
	logic [15:0] torque = 16'h0;
	logic [31:0] rdat;
	logic        ack, pulse, dir, cw, ccw, ten, dyn, step, sdir;
	logic        fault, reach, brake, warn, irq;
	int          mismatches = 0;
	int          samples_checked = 0;
	always #10 clk = ~clk;
	sio_host_model i_sio_host_model (.i_sys_clk(clk), .i_cmd_step(step), .i_cmd_dir(sdir), .o_pulse(pulse),
		.o_dir(dir), .o_cw_closed(cw), .o_ccw_closed(ccw));
	sio_io_logic #(.HOLD_CYC(20)) i_sio_io_logic (.i_sys_clk(clk), .i_rst(rst), .i_clk_en(en), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_cw_limit_inhibit(cw), .i_ccw_limit_inhibit(ccw), .i_cmd_pulse_pos(pulse),
		.i_cmd_dir_pos(dir), .i_alarm_detect(alarm), .i_pos_err(pos_err), .i_motor_speed(speed),
		.i_eff_torque(torque), .i_torque_limiting(tlim), .i_regen_warn(regen), .o_torque_enable(ten),
		.o_dyn_brake_allow(dyn), .o_cmd_step(step), .o_cmd_dir(sdir), .o_servo_fault_out(fault),
		.o_position_or_speed_reached(reach), .o_holding_brake_release(brake), .o_warning_out(warn), .o_irq(irq));
	task automatic conclude;
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			mismatches++;
			$display("mismatch at %0t: no bus acknowledge", $time);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	task automatic t_reset;
		rd_chk(ADR_CTRL, 32'h1);
		rd_chk(8'h40, 32'h0);
		i_sio_host_model.lim(1'b0, 1'b0);
		pause(6);
		chk(ten, 1'b1);
		i_sio_host_model.lim(1'b1, 1'b1);
		pause(3);
		rd_chk(ADR_STATUS, 32'h17);
	endtask
	task automatic t_overtravel;
		wr(ADR_IRQ_MASK, 32'h1f);
		wr(ADR_CTRL, 32'h0);
		i_sio_host_model.lim(1'b0, 1'b1);
		pause(6);
		chk(ten, 1'b0);
		chk(dyn, 1'b1);
		chk(irq, 1'b1);
		rd_chk(ADR_IRQ_ST, 32'h1);
		wr(ADR_IRQ_ST, 32'h1);
		pause(1);
		chk(irq, 1'b0);
		i_sio_host_model.lim(1'b1, 1'b0);
		pause(6);
		chk(ten, 1'b0);
		wr(ADR_CTRL, 32'h2);
		pause(3);
		chk(dyn, 1'b0);
		wr(ADR_CTRL, 32'h1);
		pause(3);
		chk(ten, 1'b1);
		i_sio_host_model.lim(1'b1, 1'b1);
		wr(ADR_IRQ_ST, 32'h1f);
	endtask
	task automatic t_pulse;
		for (int f = 0; f < 3; f++) begin
			wr(ADR_CTRL, 32'(1 + (f << CB_FMT_LO)));
			i_sio_host_model.n_up = 0;
			i_sio_host_model.n_dn = 0;
			repeat (6) i_sio_host_model.step(f[1:0], 1'b0);
			repeat (2) i_sio_host_model.step(f[1:0], 1'b1);
			pause(5);
			chk(i_sio_host_model.n_up, 32'd6);
			chk(i_sio_host_model.n_dn, 32'd2);
			rd_chk(ADR_PCOUNT, 32'(4 * (f + 1)));
		end
		wr(ADR_CTRL, 32'hd);
		i_sio_host_model.step(2'h2, 1'b0);
		pause(5);
		rd_chk(ADR_PCOUNT, 32'hc);
	endtask
	task automatic t_alarm;
		wr(ADR_CTRL, 32'h101);
		pause(3);
		chk(fault, 1'b1);
		chk(brake, 1'b1);
		en <= 1'b0;
		alarm <= 1'b1;
		pause(3);
		chk(fault, 1'b1);
		en <= 1'b1;
		alarm <= 1'b1;
		pause(3);
		chk(fault, 1'b0);
		chk(brake, 1'b0);
		chk(irq, 1'b1);
		wr(ADR_IRQ_MASK, 32'h0);
		pause(1);
		chk(irq, 1'b0);
		rd_chk(ADR_IRQ_ST, 32'h4);
		wr(ADR_IRQ_MASK, 32'h1f);
		wr(ADR_IRQ_ST, 32'h4);
		pause(1);
		chk(irq, 1'b0);
		alarm <= 1'b0;
		pause(3);
		chk(brake, 1'b1);
	endtask
	task automatic t_reached;
		wr(ADR_INPOS, 32'h10);
		pos_err <= 16'h000f;
		pause(3);
		chk(reach, 1'b1);
		pos_err <= 16'h0010;
		pause(3);
		chk(reach, 1'b0);
		wr(ADR_SPEED, 32'h100);
		wr(ADR_CTRL, 32'h11);
		speed <= 16'h0100;
		pause(3);
		chk(reach, 1'b0);
		speed <= 16'h0101;
		pause(3);
		chk(reach, 1'b1);
		rd_chk(ADR_IRQ_ST, 32'h10);
	endtask
	task automatic t_warn;
		wr(ADR_CTRL, 32'h1);
		tlim <= 1'b1;
		pause(3);
		chk(warn, 1'b1);
		tlim <= 1'b0;
		pause(15);
		chk(warn, 1'b1);
		pause(10);
		chk(warn, 1'b0);
		wr(ADR_ZERO, 32'h20);
		wr(ADR_CTRL, 32'h21);
		pause(3);
		chk(warn, 1'b0);
		speed <= 16'h001f;
		pause(3);
		chk(warn, 1'b1);
		speed <= 16'h0101;
		wr(ADR_OVL_TRIP, 32'h64);
		wr(ADR_CTRL, 32'h81);
		torque <= 16'h0055;
		pause(25);
		chk(warn, 1'b0);
		torque <= 16'h0056;
		pause(3);
		chk(warn, 1'b1);
		torque <= 16'h0000;
		wr(ADR_CTRL, 32'h41);
		pause(25);
		chk(warn, 1'b0);
		regen <= 1'b1;
		pause(3);
		chk(warn, 1'b1);
		regen <= 1'b0;
		torque <= 16'h0056;
		pause(25);
		chk(warn, 1'b1);
		wr(ADR_CTRL, 32'h61);
		pause(25);
		chk(warn, 1'b0);
		regen <= 1'b1;
		pause(3);
		chk(warn, 1'b1);
		regen <= 1'b0;
		torque <= 16'h0000;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		$display("mismatch at %0t: watchdog expired", $time);
		conclude();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_overtravel();
		t_pulse();
		t_alarm();
		t_reached();
		t_warn();
		conclude();
	end
endmodule
